// file: rtl/dip_pkg.sv
// package for the data input pre-processing block
package dip_pkg;
  // register byte offsets
  localparam logic [7:0] DIP_OFF_CTRL = 8'h00;
  localparam logic [7:0] DIP_OFF_INV = 8'h04;
  localparam logic [7:0] DIP_OFF_FEN = 8'h08;
  localparam logic [7:0] DIP_OFF_TSEL = 8'h0c;
  localparam logic [7:0] DIP_OFF_STAT = 8'h10;
  // control field positions
  localparam int DIP_CTRL_JOINT_BIT = 0;
  localparam int DIP_CTRL_GATE_BIT = 1;
  localparam int DIP_CTRL_PMUX_BIT = 2;
  localparam int DIP_CTRL_FAST_BIT = 3;
  // reset values
  localparam logic [3:0] DIP_CTRL_RST = 4'h0;
  localparam logic [3:0] DIP_INV_RST = 4'h0;
  localparam logic [3:0] DIP_FEN_RST = 4'h0;
  localparam logic [2:0] DIP_TSEL_RST = 3'h0;
  localparam logic [2:0] DIP_TSEL_CYCLE = 3'h7;
  // timing
  localparam int DIP_CLK_MHZ = 40;
  localparam int DIP_TICK_US = 1;
  localparam int DIP_TICK_CYC = DIP_TICK_US * DIP_CLK_MHZ;
  localparam int DIP_BASE_US = 128;
  // least time less 6.25 percent: 120 ticks
  localparam int DIP_BASE_TICKS = DIP_BASE_US - DIP_BASE_US / 16;
  localparam int DIP_BLOCK_US = 256;
  localparam int DIP_BLOCK_TICKS = DIP_BLOCK_US - DIP_BLOCK_US / 16;
  localparam int DIP_LATCH_MIN_NS = 11000;
  localparam int DIP_LATCH_MAX_NS = 13500;
  localparam int DIP_CLK_NS = 25;
  // sample midway in the acceptance window
  localparam int DIP_LATCH_CYC = (DIP_LATCH_MIN_NS + DIP_LATCH_MAX_NS) / 2 / DIP_CLK_NS;
  // axi answer codes
  localparam logic [1:0] DIP_RESP_OKAY = 2'b00;
  localparam logic [1:0] DIP_RESP_SLVERR = 2'b10;
  // configuration carried as one struct
  typedef struct packed {
    logic joint_invert;
    logic pin_gated_filter_flag;
    logic [3:0] per_channel_invert_mask;
    logic [3:0] per_channel_filter_enable;
    logic [2:0] debounce_time_select;
  } dip_cfg_t;
endpackage : dip_pkg

// file: rtl/dip_top.sv
// data input inversion, debounce and response selection with axi4-lite registers
`timescale 1ns/100ps
module dip_top import dip_pkg::*; #(
  parameter int NCH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins and protocol side
  input wire logic [NCH-1:0] data_input_pins,
  input wire logic parameter_pin_one,
  input wire logic init_done,
  input wire logic data_strobe,
  input wire logic exchange_call,
  input wire logic clock_is_8mhz,
  output logic [NCH-1:0] response_data,
  output logic response_valid,
  output logic pin_one_mux_allowed
);
  // pin synchronisers: stage one read only by stage two
  logic [NCH+1:0] sync1_reg, sync2_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {parameter_pin_one, init_done, data_input_pins};
      sync2_reg <= sync1_reg;
    end
  end
  logic [NCH-1:0] pin_s;
  logic p1_s, init_s;
  assign pin_s = sync2_reg[NCH-1:0];
  assign init_s = sync2_reg[NCH];
  assign p1_s = sync2_reg[NCH+1];

  // registers
  logic [3:0] ctrl_reg, ctrl_next;
  logic [3:0] inv_reg, inv_next;
  logic [3:0] fen_reg, fen_next;
  logic [2:0] tsel_reg, tsel_next;
  dip_cfg_t cfg;
  assign cfg = '{joint_invert: ctrl_reg[DIP_CTRL_JOINT_BIT],
                 pin_gated_filter_flag: ctrl_reg[DIP_CTRL_GATE_BIT],
                 per_channel_invert_mask: inv_reg,
                 per_channel_filter_enable: fen_reg,
                 debounce_time_select: tsel_reg};

  // axi write and read channel state
  logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next, bvalid_reg, bvalid_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arvalid_busy;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;

  // address is mapped when it hits one of the five words
  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == DIP_OFF_CTRL) || (a == DIP_OFF_INV) || (a == DIP_OFF_FEN)
            || (a == DIP_OFF_TSEL) || (a == DIP_OFF_STAT);
  endfunction : addr_hit

  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // status view of the block
  logic [NCH-1:0] filt_reg, filt_next;
  logic [31:0] stat_word;

  // strobe of the write data beat, held with the data
  logic wstrb0_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) wstrb0_reg <= 1'b0;
    else if (s_axi_wvalid && s_axi_wready) wstrb0_reg <= s_axi_wstrb[0];
  end
  function automatic logic s_axi_wstrb_lane0(input logic [3:0] s, input logic held);
    s_axi_wstrb_lane0 = held ? wstrb0_reg : s[0];
  endfunction : s_axi_wstrb_lane0

  // write path next state
  always_comb begin
    logic do_wr;
    logic [7:0] a;
    logic [31:0] d;
    do_wr = 1'b0;
    a = awaddr_reg;
    d = wdata_reg;
    aw_hold_next = aw_hold_reg;
    w_hold_next = w_hold_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    ctrl_next = ctrl_reg;
    inv_next = inv_reg;
    fen_next = fen_reg;
    tsel_next = tsel_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_next = 1'b1;
      awaddr_next = s_axi_awaddr;
      a = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_hold_next = 1'b1;
      wdata_next = s_axi_wdata;
      d = s_axi_wdata;
    end
    // both halves present: commit and answer
    if (aw_hold_next && w_hold_next && !bvalid_reg) begin
      do_wr = 1'b1;
      aw_hold_next = 1'b0;
      w_hold_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = addr_hit(a) ? DIP_RESP_OKAY : DIP_RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // only lane zero carries the narrow fields
    if (do_wr && s_axi_wstrb_lane0(s_axi_wstrb, w_hold_reg)) begin
      unique case (a)
        DIP_OFF_CTRL: ctrl_next = d[3:0];
        DIP_OFF_INV: inv_next = d[3:0];
        DIP_OFF_FEN: fen_next = d[3:0];
        DIP_OFF_TSEL: tsel_next = d[2:0];
        default: ;
      endcase
    end
  end

  // read path: one cycle answer
  assign arvalid_busy = rvalid_reg;
  assign s_axi_arready = !arvalid_busy;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && s_axi_rready) rvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = addr_hit(s_axi_araddr) ? DIP_RESP_OKAY : DIP_RESP_SLVERR;
      unique case (s_axi_araddr)
        DIP_OFF_CTRL: rdata_next = {28'h0000000, ctrl_reg};
        DIP_OFF_INV: rdata_next = {28'h0000000, inv_reg};
        DIP_OFF_FEN: rdata_next = {28'h0000000, fen_reg};
        DIP_OFF_TSEL: rdata_next = {29'h0, tsel_reg};
        DIP_OFF_STAT: rdata_next = stat_word;
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  // register file and bus flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= DIP_CTRL_RST;
      inv_reg <= DIP_INV_RST;
      fen_reg <= DIP_FEN_RST;
      tsel_reg <= DIP_TSEL_RST;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      bvalid_reg <= 1'b0;
      bresp_reg <= DIP_RESP_OKAY;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= DIP_RESP_OKAY;
    end else begin
      ctrl_reg <= ctrl_next;
      inv_reg <= inv_next;
      fen_reg <= fen_next;
      tsel_reg <= tsel_next;
      aw_hold_reg <= aw_hold_next;
      w_hold_reg <= w_hold_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // inversion ahead of the filter
  logic [NCH-1:0] inv_in;
  assign inv_in = cfg.joint_invert ? ~pin_s
                : pin_s ^ cfg.per_channel_invert_mask[NCH-1:0];

  // microsecond tick, halved count when the crystal is the slow one
  logic [5:0] pre_reg, pre_next;
  logic tick;
  logic [5:0] pre_top;
  assign pre_top = clock_is_8mhz ? 6'(DIP_TICK_CYC / 2 - 1) : 6'(DIP_TICK_CYC - 1);
  assign tick = (pre_reg >= pre_top);

  // filter length in ticks per code
  logic [13:0] span;
  assign span = 14'(DIP_BASE_TICKS) << tsel_reg;
  logic cycle_mode;
  assign cycle_mode = (cfg.debounce_time_select == DIP_TSEL_CYCLE);

  // per channel timers, cycle mode sampler, block timer
  logic [13:0] tmr_reg [NCH];
  logic [13:0] tmr_next [NCH];
  logic [NCH-1:0] last_smp_reg, last_smp_next;
  logic [8:0] blk_reg, blk_next;
  logic [9:0] lat_reg, lat_next;
  logic lat_run_reg, lat_run_next, strobe_d_reg;
  logic sample_now, smp_ok;
  // sample point a fixed delay after the strobe rises
  assign sample_now = lat_run_reg && (lat_reg == 10'(DIP_LATCH_CYC));
  assign smp_ok = sample_now && (blk_reg == 9'h000);

  always_comb begin
    pre_next = tick ? 6'h00 : 6'(pre_reg + 6'h01);
    lat_run_next = lat_run_reg;
    lat_next = lat_reg;
    if (data_strobe && !strobe_d_reg) begin
      lat_run_next = 1'b1;
      lat_next = 10'h000;
    end else if (lat_run_reg) begin
      lat_next = 10'(lat_reg + 10'h001);
      if (sample_now) lat_run_next = 1'b0;
    end
    blk_next = blk_reg;
    // one extra tick so the partial first tick never shortens the block
    if (smp_ok) blk_next = 9'(DIP_BLOCK_TICKS + 1);
    else if (tick && blk_reg != 9'h000) blk_next = 9'(blk_reg - 9'h001);
    last_smp_next = last_smp_reg;
    filt_next = filt_reg;
    for (int n = 0; n < NCH; n++) begin
      tmr_next[n] = tmr_reg[n];
      if (!fen_reg[n]) begin
        filt_next[n] = inv_in[n];
        tmr_next[n] = 14'h0000;
      end else if (cycle_mode) begin
        tmr_next[n] = 14'h0000;
        if (smp_ok) begin
          last_smp_next[n] = inv_in[n];
          if (inv_in[n] == last_smp_reg[n]) filt_next[n] = inv_in[n];
        end
      end else if (inv_in[n] == filt_reg[n]) begin
        tmr_next[n] = 14'h0000;
      end else if (tick) begin
        // strictly past the span: the first tick may be a partial one
        if (tmr_reg[n] + 14'h0001 > span) begin
          filt_next[n] = inv_in[n];
          tmr_next[n] = 14'h0000;
        end else begin
          tmr_next[n] = 14'(tmr_reg[n] + 14'h0001);
        end
      end
    end
  end

  // filter state, held cleared until init completes
  always_ff @(posedge aclk) begin
    if (!aresetn || !init_s) begin
      filt_reg <= '0;
      last_smp_reg <= '0;
      blk_reg <= 9'h000;
      pre_reg <= 6'h00;
      lat_reg <= 10'h000;
      lat_run_reg <= 1'b0;
      strobe_d_reg <= 1'b0;
      for (int n = 0; n < NCH; n++) tmr_reg[n] <= 14'h0000;
    end else begin
      filt_reg <= filt_next;
      last_smp_reg <= last_smp_next;
      blk_reg <= blk_next;
      pre_reg <= pre_next;
      lat_reg <= lat_next;
      lat_run_reg <= lat_run_next;
      strobe_d_reg <= data_strobe;
      for (int n = 0; n < NCH; n++) tmr_reg[n] <= tmr_next[n];
    end
  end

  // response latch on an exchange call
  logic [NCH-1:0] resp_reg, resp_next;
  logic rv_reg;
  logic use_raw;
  assign use_raw = cfg.pin_gated_filter_flag && p1_s;
  assign resp_next = use_raw ? inv_in : filt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      resp_reg <= '0;
      rv_reg <= 1'b0;
    end else begin
      rv_reg <= exchange_call;
      if (exchange_call) resp_reg <= resp_next;
    end
  end
  assign response_data = resp_reg;
  assign response_valid = rv_reg;
  // pin one kept out of multiplexing while gating is on
  assign pin_one_mux_allowed = ctrl_reg[DIP_CTRL_PMUX_BIT] && !cfg.pin_gated_filter_flag;
  assign stat_word = {20'h00000, 3'h0, use_raw, resp_reg, filt_reg};
endmodule : dip_top

// file: tb/dip_sensor.sv
// switch and sensor model driving the four data input pins
`timescale 1ns/100ps
module dip_sensor (
  input wire logic aclk,
  input wire logic [3:0] level,
  input wire logic [3:0] chatter,
  output logic [3:0] pins
);
  // contact image, toggles each cycle on chattering channels
  logic [3:0] bounce_reg = 4'h0;
  // a bouncing contact never holds long enough to qualify
  always_ff @(posedge aclk) begin
    bounce_reg <= chatter & ~bounce_reg;
  end
  // steady channels hold their level through the sample window
  assign pins = level ^ bounce_reg;
endmodule : dip_sensor

// file: tb/dip_top_monitor.sv
// port assertions for the response path and register bus of dip_top
`timescale 1ns/100ps
module dip_top_monitor #(
  parameter int NCH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exchange_call,
  input wire logic [NCH-1:0] response_data,
  input wire logic response_valid
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // every exchange call is answered the next cycle
  resp_pulse_a: assert property (exchange_call |=> response_valid)
    else $error("no response after exchange call");
  resp_quiet_a: assert property (!exchange_call |=> !response_valid)
    else $error("response without exchange call");
  // previous value stands until the next call
  resp_hold_a: assert property (!exchange_call && !response_valid |=> $stable(response_data))
    else $error("response changed between calls");
  // bus answers stand until taken
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : dip_top_monitor

bind dip_top dip_top_monitor #(.NCH(NCH)) i_dip_top_monitor (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .exchange_call(exchange_call),
  .response_data(response_data), .response_valid(response_valid)
);

// file: tb/dip_top_test.sv
// register and pin level test of the data input pre-processing block
`timescale 1ns/100ps
module dip_top_test;
  import dip_pkg::*;
  logic aclk = 1'b0; // 40 mhz system clock
  logic aresetn = 1'b0; // low for the first 20 cycles
  logic [7:0] awa = 8'h00; // write address
  logic [7:0] ara = 8'h00; // read address
  logic [31:0] wd = 32'h0; // write data
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0; // bus strobes
  wire awr, wr, bv, arr, rv, rvo, mux_ok; // design answers
  wire [1:0] bresp, rresp;
  wire [31:0] rd;
  logic [3:0] lvl = 4'h0, chat = 4'h0; // sensor levels and bounce
  wire [3:0] pins, resp;
  logic p1 = 1'b0, initd = 1'b0, dsr = 1'b0, xc = 1'b0; // protocol side
  logic c8 = 1'b0; // slow crystal flag
  logic [3:0] inv_tab [4] = '{4'h0, 4'h1, 4'h8, 4'ha}; // invert masks tried
  int err_count = 0;
  int n_checks = 0;

  always #12.5 aclk = ~aclk;

  dip_sensor i_dip_sensor (.aclk(aclk), .level(lvl), .chatter(chat), .pins(pins));

  dip_top i_dip_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .data_input_pins(pins),
    .parameter_pin_one(p1), .init_done(initd), .data_strobe(dsr), .exchange_call(xc),
    .clock_is_8mhz(c8), .response_data(resp), .response_valid(rvo),
    .pin_one_mux_allowed(mux_ok)
  );

  // counted comparison of one value
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask : w

  // axi4-lite write; bready stands from the request until the answer shows
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
      if (bv) break;
    end
    br <= 1'b0;
    chk("bresp", {30'h0, DIP_RESP_OKAY}, {30'h0, bresp});
  endtask : wr_reg

  // axi4-lite read compared with data and answer code
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    rr <= 1'b0;
    chk("rdata", exp, rd);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask : rd_chk

  // one-cycle exchange call, answer read the cycle after
  task automatic xchg(input logic [3:0] exp);
    @(posedge aclk);
    xc <= 1'b1;
    @(posedge aclk);
    xc <= 1'b0;
    @(posedge aclk);
    chk("valid", 32'h1, {31'h0, rvo});
    chk("response", {28'h0, exp}, {28'h0, resp});
  endtask : xchg

  // strobe pulse of about 5.5 us, then wait past the sample point
  task automatic strobe_sample;
    @(posedge aclk);
    dsr <= 1'b1;
    w(220);
    dsr <= 1'b0;
    w(400);
  endtask : strobe_sample

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    w(20);
    aresetn <= 1'b1;
    initd <= 1'b1;
    // reset values, status included, readback and an unmapped place
    for (int i = 0; i < 5; i++) rd_chk(8'(4 * i), 32'h0, DIP_RESP_OKAY);
    rd_chk(8'h40, 32'h0, DIP_RESP_SLVERR);
    wr_reg(DIP_OFF_TSEL, 32'h5);
    rd_chk(DIP_OFF_TSEL, 32'h5, DIP_RESP_OKAY);
    $display("test registers done");
    // selective masks, then joint inversion over a live mask
    lvl <= 4'h5;
    foreach (inv_tab[i]) begin
      wr_reg(DIP_OFF_INV, {28'h0, inv_tab[i]});
      xchg(4'h5 ^ inv_tab[i]);
    end
    wr_reg(DIP_OFF_CTRL, 32'h1);
    xchg(4'ha);
    $display("test inversion done");
    // filter on channel 0 only, inversion on channel 1, bounce first
    initd <= 1'b0;
    wr_reg(DIP_OFF_CTRL, 32'h0);
    wr_reg(DIP_OFF_INV, 32'h2);
    wr_reg(DIP_OFF_FEN, 32'h1);
    wr_reg(DIP_OFF_TSEL, 32'h0);
    lvl <= 4'hf;
    chat <= 4'h1;
    initd <= 1'b1;
    w(3000);
    xchg(4'hc);
    chat <= 4'h0;
    w(4000);
    xchg(4'hc);
    w(1300);
    xchg(4'hd);
    $display("test filter done");
    // raw against filtered selection by parameter pin one
    lvl <= 4'he;
    wr_reg(DIP_OFF_CTRL, 32'h2);
    p1 <= 1'b1;
    w(5);
    xchg(4'hc);
    p1 <= 1'b0;
    w(5);
    xchg(4'hd);
    wr_reg(DIP_OFF_CTRL, 32'h0);
    p1 <= 1'b1;
    w(5);
    xchg(4'hd);
    wr_reg(DIP_OFF_CTRL, 32'h6);
    chk("mux", 32'h0, {31'h0, mux_ok});
    wr_reg(DIP_OFF_CTRL, 32'h4);
    chk("mux", 32'h1, {31'h0, mux_ok});
    // halved prescaler: channel 0 falls after about half the time
    c8 <= 1'b1;
    w(2000);
    xchg(4'hd);
    w(600);
    xchg(4'hc);
    c8 <= 1'b0;
    $display("test gate done");
    // bus cycle mode: two spaced samples, one repeat too soon
    wr_reg(DIP_OFF_CTRL, 32'h0);
    wr_reg(DIP_OFF_INV, 32'h0);
    wr_reg(DIP_OFF_FEN, 32'hf);
    wr_reg(DIP_OFF_TSEL, {29'h0, DIP_TSEL_CYCLE});
    lvl <= 4'h0;
    strobe_sample;
    w(10000);
    strobe_sample;
    xchg(4'h0);
    lvl <= 4'ha;
    w(10000);
    strobe_sample;
    xchg(4'h0);
    strobe_sample;
    xchg(4'h0);
    w(10000);
    strobe_sample;
    xchg(4'ha);
    $display("test cycle mode done");
    final_report;
  end

  // the tests need about 45k cycles
  initial begin
    w(60000);
    err_count++;
    final_report;
  end
endmodule : dip_top_test
